// File: verilog/ccs_clock_ctrl.sv
// CPU clock source selection with oscillator watchdog, modelled on one clock.
// Assumes clock_input_pin and clock_config_pins are asynchronous pins and that
// the system clock is much faster than any input clock it has to follow.

// Behaviour
// - Pins 011 at reset: PLL off unless the watchdog runs, CPU clock follows the input pin directly.
// - Pin codes other than 011 and 001 enable the PLL, CPU clock is input times factor.
// - PLL resyncs to input every F-th transition, adjusting period gradually.
// - Watchdog exists in direct and prescaler modes, enabled after each reset.
// - Setting configuration register bit 4 disables the watchdog.
// - Watchdog on: PLL free-runs, counter counts its cycles, input edges clear it.
// - Input clock failed when counter reaches 16 free-running cycles.
// - On failure CPU clock moves to free-running clock, fail flag raised.
// - Failed state holds until hardware reset even if input returns.
// - Watchdog off: CPU clock from input pin, PLL switched off.
// - Factors: 111=4, 110=3, 101=2, 100=5, 010=1.5, 000=2.5.
// - Pins 001 at reset: CPU clock is input divided by two.
module ccs_clock_ctrl #(
  parameter int FREE_DIV     = 2,  // System cycles per free-running PLL cycle
  parameter int PERIOD_WIDTH = 12  // Width of the input interval measurement
) (
  input  wire logic                                clock,                  // 50 MHz
  input  wire logic                                arst_n,                 // Async reset
  input  wire logic                                clock_input_pin,        // Input clock pin
  input  wire logic [2:0]                          clock_config_pins,      // Mode straps
  input  wire logic [ccs_pkg::SYSCFG_WIDTH-1:0]    system_config_register, // Config reg
  input  wire logic                                osc_fail_irq_clear,     // Clear pulse
  output logic                                     cpu_clk,                // CPU clock level
  output logic                                     cpu_clk_edge,           // Edge pulse
  output logic                                     pll_enable,             // PLL powered
  output logic                                     clock_failed,           // On free clock
  output logic                                     osc_fail_interrupt_request, // Sticky
  output logic                                     mode_valid,             // Mode latched
  output ccs_pkg::ccs_mode_e                       clock_mode,             // Latched mode
  output logic [3:0]                               pll_factor_x2           // Factor x2
);

  localparam int ACC_WIDTH = PERIOD_WIDTH + 2;

  if (FREE_DIV < 1 || FREE_DIV > 255) begin : g_bad_div
    $error("FREE_DIV must be between 1 and 255");
  end
  if (PERIOD_WIDTH < 4) begin : g_bad_width
    $error("PERIOD_WIDTH must be at least 4");
  end

  typedef struct packed {
    logic                    cin_s1;
    logic                    cin_s2;
    logic                    cin_prev;
    logic [2:0]              cfg_s1;
    logic [2:0]              cfg_s2;
    logic [1:0]              settle;
    logic                    cfg_done;
    ccs_pkg::ccs_mode_e      mode;
    logic [3:0]              fx2;
    logic [7:0]              free_div;
    logic                    free_pulse;
    logic [4:0]              wdog_cnt;
    logic                    failed;
    logic                    irq;
    logic [PERIOD_WIDTH-1:0] span;
    logic [PERIOD_WIDTH-1:0] avg;
    logic [3:0]              tr_cnt;
    logic [ACC_WIDTH-1:0]    acc;
    logic                    cpu_clk;
    logic                    cpu_edge;
    logic                    pll_en;
  } ccs_state_s;

  ccs_state_s st_r;
  ccs_state_s st_nxt;

  // Decode pin code into mode and doubled factor
  function automatic ccs_pkg::ccs_mode_e decode_mode(input logic [2:0] code);
    if (code == ccs_pkg::CFG_DIRECT) begin
      decode_mode = ccs_pkg::CCS_MODE_DIRECT;
    end else if (code == ccs_pkg::CFG_PRESCALE) begin
      decode_mode = ccs_pkg::CCS_MODE_PRESCALE;
    end else begin
      decode_mode = ccs_pkg::CCS_MODE_PLL;
    end
  endfunction

  function automatic logic [3:0] decode_fx2(input logic [2:0] code);
    unique case (code)
      ccs_pkg::CFG_X4:   decode_fx2 = ccs_pkg::FX2_X4;
      ccs_pkg::CFG_X3:   decode_fx2 = ccs_pkg::FX2_X3;
      ccs_pkg::CFG_X2:   decode_fx2 = ccs_pkg::FX2_X2;
      ccs_pkg::CFG_X5:   decode_fx2 = ccs_pkg::FX2_X5;
      ccs_pkg::CFG_X1P5: decode_fx2 = ccs_pkg::FX2_X1P5;
      ccs_pkg::CFG_X2P5: decode_fx2 = ccs_pkg::FX2_X2P5;
      default:           decode_fx2 = ccs_pkg::FX2_X1;
    endcase
  endfunction

  logic                    wdog_disable;
  logic                    in_edge;
  logic                    wdog_active;
  logic                    pll_tick;
  logic [3:0]              resync_n;
  logic [ACC_WIDTH-1:0]    acc_sum;
  logic [ACC_WIDTH-1:0]    modulus;
  logic [PERIOD_WIDTH:0]   avg_sum;

  always_comb begin
    wdog_disable = system_config_register[ccs_pkg::SYSCFG_WDOG_DISABLE_BIT];
    in_edge     = st_r.cin_s2 ^ st_r.cin_prev;
    resync_n    = (st_r.fx2 >> 1) == 4'h0 ? 4'h1 : (st_r.fx2 >> 1);
    modulus     = {1'b0, st_r.avg, 1'b0};
    acc_sum     = st_r.acc + ACC_WIDTH'(st_r.fx2);
    avg_sum     = {1'b0, st_r.avg} + {1'b0, st_r.span};
    wdog_active = st_r.cfg_done && st_r.mode != ccs_pkg::CCS_MODE_PLL
                  && !wdog_disable && !st_r.failed;
    pll_tick    = 1'b0;

    st_nxt            = st_r;
    st_nxt.cin_s1     = clock_input_pin;
    st_nxt.cin_s2     = st_r.cin_s1;
    st_nxt.cin_prev   = st_r.cin_s2;
    st_nxt.cfg_s1     = clock_config_pins;
    st_nxt.cfg_s2     = st_r.cfg_s1;
    st_nxt.cpu_edge   = 1'b0;
    st_nxt.free_pulse = 1'b0;

    // Straps are caught once the synchroniser has filled after release
    if (!st_r.cfg_done) begin
      if (st_r.settle == ccs_pkg::CFG_SETTLE_CYCLES) begin
        st_nxt.cfg_done = 1'b1;
        st_nxt.mode     = decode_mode(st_r.cfg_s2);
        st_nxt.fx2      = decode_fx2(st_r.cfg_s2);
      end else begin
        st_nxt.settle = st_r.settle + 2'h1;
      end
    end

    // Free-running PLL cycle as an enable pulse
    if (st_r.free_div == 8'(FREE_DIV - 1)) begin
      st_nxt.free_div   = 8'h00;
      st_nxt.free_pulse = 1'b1;
    end else begin
      st_nxt.free_div = st_r.free_div + 8'h01;
    end

    // Watchdog: an input edge clears, a free cycle counts, 16 cycles overflow
    if (!wdog_active || in_edge) begin
      st_nxt.wdog_cnt = 5'h00;
    end else if (st_r.free_pulse) begin
      if (st_r.wdog_cnt == ccs_pkg::WDOG_LAST_COUNT) begin
        st_nxt.wdog_cnt = 5'h00;
        st_nxt.failed   = 1'b1;
      end else begin
        st_nxt.wdog_cnt = st_r.wdog_cnt + 5'h01;
      end
    end

    // Set wins over a clear arriving in the same cycle
    if (osc_fail_irq_clear) begin
      st_nxt.irq = 1'b0;
    end
    if (wdog_active && !in_edge && st_r.free_pulse
        && st_r.wdog_cnt == ccs_pkg::WDOG_LAST_COUNT) begin
      st_nxt.irq = 1'b1;
    end

    // Input interval measurement, saturating when the input is slow
    if (in_edge) begin
      st_nxt.span = PERIOD_WIDTH'(1);
    end else if (st_r.span != {PERIOD_WIDTH{1'b1}}) begin
      st_nxt.span = st_r.span + PERIOD_WIDTH'(1);
    end

    // Period estimate moves halfway to the measured interval every F-th edge,
    // so the CPU rate creeps rather than jumps when the input drifts
    if (in_edge && st_r.mode == ccs_pkg::CCS_MODE_PLL) begin
      if (st_r.tr_cnt + 4'h1 >= resync_n) begin
        st_nxt.tr_cnt = 4'h0;
        if (st_r.avg == '0) begin
          st_nxt.avg = st_r.span;
        end else begin
          st_nxt.avg = avg_sum[PERIOD_WIDTH:1];
        end
      end else begin
        st_nxt.tr_cnt = st_r.tr_cnt + 4'h1;
      end
    end

    // Rate generator: F CPU edges per input transition interval
    if (st_r.mode == ccs_pkg::CCS_MODE_PLL && st_r.avg != '0) begin
      if (acc_sum >= modulus) begin
        st_nxt.acc = acc_sum - modulus;
        pll_tick   = 1'b1;
      end else begin
        st_nxt.acc = acc_sum;
      end
    end

    // CPU clock source selection
    if (st_r.cfg_done) begin
      if (st_r.failed) begin
        if (st_r.free_pulse) begin
          st_nxt.cpu_clk  = !st_r.cpu_clk;
          st_nxt.cpu_edge = 1'b1;
        end
      end else begin
        unique case (st_r.mode)
          ccs_pkg::CCS_MODE_DIRECT: begin
            if (in_edge) begin
              st_nxt.cpu_clk  = st_r.cin_s2;
              st_nxt.cpu_edge = 1'b1;
            end
          end
          ccs_pkg::CCS_MODE_PRESCALE: begin
            if (in_edge && st_r.cin_s2) begin
              st_nxt.cpu_clk  = !st_r.cpu_clk;
              st_nxt.cpu_edge = 1'b1;
            end
          end
          ccs_pkg::CCS_MODE_PLL: begin
            if (pll_tick) begin
              st_nxt.cpu_clk  = !st_r.cpu_clk;
              st_nxt.cpu_edge = 1'b1;
            end
          end
        endcase
      end
    end

    // PLL runs for its own mode, for the watchdog, or as the fallback clock
    st_nxt.pll_en = st_r.cfg_done && (st_r.mode == ccs_pkg::CCS_MODE_PLL
                    || st_r.failed || !wdog_disable);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{
        cin_s1: 1'b0, cin_s2: 1'b0, cin_prev: 1'b0,
        cfg_s1: 3'h0, cfg_s2: 3'h0, settle: 2'h0, cfg_done: 1'b0,
        mode: ccs_pkg::CCS_MODE_DIRECT, fx2: ccs_pkg::FX2_RESET,
        free_div: 8'h00, free_pulse: 1'b0, wdog_cnt: 5'h00,
        failed: 1'b0, irq: 1'b0, span: '0, avg: '0, tr_cnt: 4'h0,
        acc: '0, cpu_clk: 1'b0, cpu_edge: 1'b0, pll_en: 1'b0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    cpu_clk                    = st_r.cpu_clk;
    cpu_clk_edge               = st_r.cpu_edge;
    pll_enable                 = st_r.pll_en;
    clock_failed               = st_r.failed;
    osc_fail_interrupt_request = st_r.irq;
    mode_valid                 = st_r.cfg_done;
    clock_mode                 = st_r.mode;
    pll_factor_x2              = st_r.fx2;
  end

endmodule

// File: verilog/ccs_pkg.sv
// Constants and types for the CPU clock select and oscillator watchdog block.
// Assumes a single 50 MHz system clock; all derived clocks are enable pulses.
package ccs_pkg;

  // Clock generation modes chosen by the configuration pins at reset
  typedef enum logic [1:0] {
    CCS_MODE_PLL,
    CCS_MODE_DIRECT,
    CCS_MODE_PRESCALE
  } ccs_mode_e;

  // Configuration pin codes
  localparam logic [2:0] CFG_DIRECT   = 3'h3;
  localparam logic [2:0] CFG_PRESCALE = 3'h1;
  localparam logic [2:0] CFG_X4       = 3'h7;
  localparam logic [2:0] CFG_X3       = 3'h6;
  localparam logic [2:0] CFG_X2       = 3'h5;
  localparam logic [2:0] CFG_X5       = 3'h4;
  localparam logic [2:0] CFG_X1P5     = 3'h2;
  localparam logic [2:0] CFG_X2P5     = 3'h0;

  // Multiply factors in half steps (factor times two)
  localparam logic [3:0] FX2_X4   = 4'h8;
  localparam logic [3:0] FX2_X3   = 4'h6;
  localparam logic [3:0] FX2_X2   = 4'h4;
  localparam logic [3:0] FX2_X5   = 4'hA;
  localparam logic [3:0] FX2_X1P5 = 4'h3;
  localparam logic [3:0] FX2_X2P5 = 4'h5;
  localparam logic [3:0] FX2_X1   = 4'h2;

  // Watchdog-disable bit position in the system configuration register
  localparam int         SYSCFG_WDOG_DISABLE_BIT = 4;
  localparam int         SYSCFG_WIDTH            = 16;

  // Watchdog overflow after this many free-running clock cycles
  localparam int         WDOG_OVERFLOW_CYCLES = 16;
  localparam logic [4:0] WDOG_LAST_COUNT      = 5'(WDOG_OVERFLOW_CYCLES - 1);

  // Cycles after reset release before the synchronised pins are trusted
  localparam logic [1:0] CFG_SETTLE_CYCLES = 2'h2;

  // Reset values
  localparam logic [3:0] FX2_RESET  = FX2_X1;

endpackage

// File: dv/ccs_osc_src.sv
// External clock source model for the input clock pin.
// Assumes half_ns is a positive multiple of 20 ns; a stopped source holds its level.
module ccs_osc_src (
  input  logic        run,     // Source alive
  input  int unsigned half_ns, // Half period
  output logic        pin      // Clock pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // A fixed 5 ns phase keeps every pin edge off both bench clock edges, so the
  // design and the assertions always see the same sample of the pin
  initial begin
    pin = 1'b0;
    #5;
    forever begin
      #(half_ns);
      if (run) begin
        pin = ~pin;
      end
    end
  end
endmodule

// File: dv/ccs_clock_ctrl_sva.sv
// Assertions on the clock select block ports.
// Assumes a bind into ccs_clock_ctrl that hands on FREE_DIV.
module ccs_clock_ctrl_chk #(
  parameter int FREE_DIV = 2  // Tick spacing
) (
  input logic               clock,                      // In
  input logic               arst_n,                     // In
  input logic               clock_input_pin,            // In
  input logic [2:0]         clock_config_pins,          // In
  input logic [15:0]        system_config_register,     // In
  input logic               osc_fail_irq_clear,         // In
  input logic               cpu_clk,                    // Out
  input logic               cpu_clk_edge,               // Out
  input logic               pll_enable,                 // Out
  input logic               clock_failed,               // Out
  input logic               osc_fail_interrupt_request, // Out
  input logic               mode_valid,                 // Out
  input ccs_pkg::ccs_mode_e clock_mode,                 // Out
  input logic [3:0]         pll_factor_x2               // Out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] FX2 [8] = '{4'h5, 4'h2, 4'h3, 4'h2, 4'hA, 4'h4, 4'h6, 4'h8};
  logic       act;
  logic [7:0] quiet_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Pin quiet time: the watchdog must not fire ahead of its count
  assign act = mode_valid && clock_mode != ccs_pkg::CCS_MODE_PLL && !system_config_register[4];
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) quiet_r <= 8'h00;
    else if (!act || $changed(clock_input_pin)) quiet_r <= 8'h00;
    else if (quiet_r != 8'hFF) quiet_r <= quiet_r + 8'h01;
  a_fail_sticky:
    assert property (clock_failed |=> clock_failed) else $error("failed dropped");
  a_fail_flags:
    assert property ($rose(clock_failed) |-> osc_fail_interrupt_request && pll_enable)
    else $error("fail without flag");
  a_irq_clear:
    assert property (osc_fail_irq_clear && clock_failed |=> !osc_fail_interrupt_request)
    else $error("flag not cleared");
  a_irq_hold:
    assert property (osc_fail_interrupt_request && !osc_fail_irq_clear
      |=> osc_fail_interrupt_request) else $error("flag lost");
  a_mode_held:
    assert property (mode_valid |=> mode_valid && $stable(clock_mode)
      && $stable(pll_factor_x2)) else $error("mode changed");
  a_mode_map:
    assert property ($rose(mode_valid) |-> clock_mode == (clock_config_pins == 3'h3 ?
      ccs_pkg::CCS_MODE_DIRECT : clock_config_pins == 3'h1 ? ccs_pkg::CCS_MODE_PRESCALE :
      ccs_pkg::CCS_MODE_PLL)) else $error("wrong mode");
  a_factor_map:
    assert property ($rose(mode_valid) && clock_mode == ccs_pkg::CCS_MODE_PLL
      |-> pll_factor_x2 == FX2[clock_config_pins]) else $error("wrong factor");
  a_fail_early:
    assert property ($rose(clock_failed) |-> quiet_r >= 8'(15 * FREE_DIV))
    else $error("early fail");
  // Pin edge reaches the CPU clock three samples later through the synchroniser
  a_direct_follow:
    assert property (mode_valid && clock_mode == ccs_pkg::CCS_MODE_DIRECT && !clock_failed
      && cpu_clk_edge |-> cpu_clk == $past(clock_input_pin, 3))
    else $error("cpu clock not following pin");
endmodule
bind ccs_clock_ctrl ccs_clock_ctrl_chk #(.FREE_DIV(FREE_DIV)) u_chk (
  .clock                      (clock),
  .arst_n                     (arst_n),
  .clock_input_pin            (clock_input_pin),
  .clock_config_pins          (clock_config_pins),
  .system_config_register     (system_config_register),
  .osc_fail_irq_clear         (osc_fail_irq_clear),
  .cpu_clk                    (cpu_clk),
  .cpu_clk_edge               (cpu_clk_edge),
  .pll_enable                 (pll_enable),
  .clock_failed               (clock_failed),
  .osc_fail_interrupt_request (osc_fail_interrupt_request),
  .mode_valid                 (mode_valid),
  .clock_mode                 (clock_mode),
  .pll_factor_x2              (pll_factor_x2)
);

// File: dv/ccs_clock_ctrl_test.sv
// Self-checking bench for the clock select and oscillator watchdog block.
// Assumes the bound checker and the ccs_osc_src clock source model.
`define CCS_CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module ccs_clock_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct { int kind; logic [7:0] exp; int tol; string nm; } ccs_note_s;
  localparam int FD = 2;
  localparam logic [3:0] FX2 [8] = '{4'h5, 4'h2, 4'h3, 4'h2, 4'hA, 4'h4, 4'h6, 4'h8};
  logic               clock = 1'b0;
  logic               arst_n = 1'b0;
  logic               clock_input_pin;
  logic [2:0]         clock_config_pins = 3'h7;
  logic [15:0]        system_config_register = 16'h0000;
  logic               osc_fail_irq_clear = 1'b0;
  logic               cpu_clk, cpu_clk_edge, pll_enable, clock_failed, mode_valid;
  logic               osc_fail_interrupt_request;
  ccs_pkg::ccs_mode_e clock_mode;
  logic [3:0]         pll_factor_x2;
  logic               osc_run = 1'b1, smp = 1'b0, cnt_clr = 1'b0;
  logic [7:0]         edge_cnt = 8'h00, got;
  int unsigned        half_ns = 500;
  int                 error_cnt = 0, num_checks = 0;
  ccs_note_s          q[$];
  ccs_note_s          n;
  always #10 clock = ~clock;
  ccs_clock_ctrl #(.FREE_DIV(FD)) u_dut (
    .clock                      (clock),
    .arst_n                     (arst_n),
    .clock_input_pin            (clock_input_pin),
    .clock_config_pins          (clock_config_pins),
    .system_config_register     (system_config_register),
    .osc_fail_irq_clear         (osc_fail_irq_clear),
    .cpu_clk                    (cpu_clk),
    .cpu_clk_edge               (cpu_clk_edge),
    .pll_enable                 (pll_enable),
    .clock_failed               (clock_failed),
    .osc_fail_interrupt_request (osc_fail_interrupt_request),
    .mode_valid                 (mode_valid),
    .clock_mode                 (clock_mode),
    .pll_factor_x2              (pll_factor_x2)
  );
  ccs_osc_src u_osc (.run(osc_run), .half_ns(half_ns), .pin(clock_input_pin));
  always @(posedge clock) begin
    if (cnt_clr) edge_cnt <= 8'h00;
    else if (cpu_clk_edge === 1'b1) edge_cnt <= edge_cnt + 8'h01;
    if (smp && q.size() > 0) begin
      n = q.pop_front();
      case (n.kind)
        0: got = 8'(clock_mode);
        1: got = 8'(pll_factor_x2);
        2: got = 8'(clock_failed);
        3: got = 8'(osc_fail_interrupt_request);
        4: got = 8'(pll_enable);
        default: got = edge_cnt;
      endcase
      if (got + n.tol >= n.exp && got <= n.exp + n.tol) got = n.exp;
      `CCS_CHK(n.nm, n.exp, got)
    end
  end
  task automatic note(input string nm, input int kind, input logic [7:0] e, input int tol);
    q.push_back('{kind, e, tol, nm});
    smp <= 1'b1;
    @(posedge clock);
    smp <= 1'b0;
    @(posedge clock);
  endtask
  task automatic clr_cnt();
    cnt_clr <= 1'b1;
    @(posedge clock);
    cnt_clr <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    logic [2:0] c;
    int         per;
    logic       fl;
    void'($urandom(20783));
    for (int i = 0; i < 9; i++) begin
      @(posedge clock);
      c = (i < 8) ? 3'(i) : 3'h3;
      arst_n <= 1'b0;
      clock_config_pins <= c;
      system_config_register <= (16'($urandom) & 16'hFFEF) | {11'h000, i == 8, 4'h0};
      // Half period of 10 to 25 cycles stays inside the 16-tick watchdog window
      half_ns <= 20 * (10 + $urandom % 16);
      osc_run <= 1'b1;
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      repeat (8) @(posedge clock);
      clock_config_pins <= 3'($urandom);  // Late strap changes must be ignored
      per = (c == 3'h3) ? 2 : (c == 3'h1) ? 1 : int'(FX2[c]);
      fl = i < 8 && per < 3;
      note("clock_mode", 0, 8'(c == 3'h3 ? ccs_pkg::CCS_MODE_DIRECT : c == 3'h1 ?
        ccs_pkg::CCS_MODE_PRESCALE : ccs_pkg::CCS_MODE_PLL), 0);
      if (per > 2) note("pll_factor_x2", 1, 8'(per), 0);
      note("pll_enable", 4, 8'(i < 8), 0);
      repeat (16 * half_ns / 20) @(posedge clock);
      clr_cnt();
      repeat (16 * half_ns / 20) @(posedge clock);
      note("cpu_edges", 5, 8'(8 * per), (per > 2) ? 2 * per : 1);
      osc_run <= 1'b0;
      repeat (60) @(posedge clock);
      note("clock_failed", 2, 8'(fl), 0);
      note("irq", 3, 8'(fl), 0);
      if (fl) begin
        clr_cnt();
        repeat (40) @(posedge clock);
        note("free_edges", 5, 8'(40 / FD), 2);
        osc_run <= 1'b1;
        repeat (100) @(posedge clock);
        note("clock_failed", 2, 8'h01, 0);
        osc_fail_irq_clear <= 1'b1;
        @(posedge clock);
        osc_fail_irq_clear <= 1'b0;
        note("irq", 3, 8'h00, 0);
      end
      $display("test %0d straps %0h done", i, c);
    end
    tally_and_finish();
  end
  initial begin
    #(40000 * 20);
    error_cnt++;
    $display("FAIL watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule
